// file: guard_byte_ram.sv
// Single-port byte memory with registered read data
`timescale 1ns/1ps
module guard_byte_ram #(
  parameter int DEPTH = 16384,
  parameter int AW = 14,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Registered read of the addressed byte returns the old contents when the same address is written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : guard_byte_ram

// file: guard_part_map.sv
// Maps device address, table and byte address to partition and memory location
`timescale 1ns/1ps
module guard_part_map
  import guard_pkg::*;
(
  input wire logic is_diag,
  input wire logic [7:0] table_sel,
  input wire logic [7:0] byte_addr,
  output part_t part,
  output logic mapped,
  output logic open_byte,
  output logic [MEM_AW-1:0] phys
);
  // Decode one access; unmapped means invalid table or open byte
  always_comb begin
    // anything unmatched falls in the reserved partition
    part = PART_RESERVED;
    mapped = 1'b0;
    open_byte = 1'b0;
    phys = {table_sel[6:0], byte_addr[6:0]};
    // identification space: serial ID, vendor, reserved upper
    if (!is_diag) begin
      mapped = 1'b1;
      phys = {SLOT_ID_LOWER, byte_addr[6:0]};
      if (byte_addr <= ID_LAST) begin
        part = PART_SERIAL_ID;
      end else if (!byte_addr[7]) begin
        part = PART_VENDOR;
      end else begin
        phys = {SLOT_ID_UPPER, byte_addr[6:0]};
      end
    end else if (!byte_addr[7]) begin
      mapped = 1'b1;
      phys = {SLOT_DIAG_LOWER, byte_addr[6:0]};
      if (byte_addr <= DIAG1_LAST) begin
        part = PART_DIAG1;
      end else if (byte_addr <= DIAG2_LAST) begin
        part = PART_DIAG2;
      end else if (byte_addr <= FWREV_LAST) begin
        part = PART_VENDOR;
      end else begin
        mapped = 1'b0;
        open_byte = 1'b1;
      end
    end else if (table_sel == TABLE_BASE) begin
      // table zero upper: user, then vendor
      mapped = 1'b1;
      phys = {SLOT_DIAG_T0_UPPER, byte_addr[6:0]};
      part = (byte_addr <= USER0_LAST) ? PART_USER : PART_VENDOR;
    end else if (table_sel == TABLE_USER) begin
      mapped = 1'b1;
      part = PART_USER;
    end else if (table_sel == TABLE_VENDOR) begin
      mapped = 1'b1;
      part = PART_VENDOR;
    end else if (table_sel == TABLE_DEVREG1) begin
      mapped = 1'b1;
      part = PART_DEVREG1;
    end else if (table_sel == TABLE_DEVREG2) begin
      mapped = 1'b1;
      part = PART_DEVREG2;
    end else if (table_sel >= TABLE_PROGRAM_DATA_RAM_FIRST && table_sel <= TABLE_PROGRAM_DATA_RAM_LAST) begin
      mapped = 1'b1;
      part = PART_PROGRAM_DATA_RAM;
    end
  end
endmodule : guard_part_map

// file: guard_pkg.sv
// Constants, types and carriers shared by the host table access guard
package guard_pkg;
  // Memory geometry
  localparam int MEM_BYTES = 16384;
  localparam int MEM_AW = 14;
  localparam int N_LEVELS = 4;
  localparam int N_PARTS = 9;
  localparam int PW_W = 32;
  // Byte addresses inside a device address
  localparam logic [7:0] ID_LAST = 8'h5F;
  localparam logic [7:0] DIAG1_LAST = 8'h5F;
  localparam logic [7:0] DIAG2_LAST = 8'h77;
  localparam logic [7:0] FWREV_LAST = 8'h7A;
  localparam logic [7:0] PW_FIRST = 8'h7B;
  localparam logic [7:0] PTR_ADDR = 8'h7F;
  localparam logic [7:0] USER0_LAST = 8'hF7;
  // Table numbers
  localparam logic [7:0] TABLE_BASE = 8'h00;
  localparam logic [7:0] TABLE_USER = 8'h01;
  localparam logic [7:0] TABLE_VENDOR = 8'h02;
  localparam logic [7:0] TABLE_DEVREG1 = 8'h03;
  localparam logic [7:0] TABLE_DEVREG2 = 8'h04;
  localparam logic [7:0] TABLE_PROGRAM_DATA_RAM_FIRST = 8'h05;
  localparam logic [7:0] TABLE_PROGRAM_DATA_RAM_LAST = 8'h7A;
  // Physical 128-byte slots for areas that have no table of their own
  localparam logic [6:0] SLOT_DIAG_T0_UPPER = 7'h00;
  localparam logic [6:0] SLOT_DIAG_LOWER = 7'h7B;
  localparam logic [6:0] SLOT_ID_LOWER = 7'h7C;
  localparam logic [6:0] SLOT_ID_UPPER = 7'h7D;
  // Reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [PW_W-1:0] ENTRY_RESET = 32'h0000_0000;
  // Value driven in the acknowledge slot
  localparam logic ACK_BIT = 1'b0;
  localparam logic NACK_BIT = 1'b1;
  // Two-wire device addresses (8-bit form shifted down to 7 bits)
  localparam logic [6:0] ID_DEV_DEFAULT = 7'h50;
  localparam logic [6:0] DIAG_DEV_DEFAULT = 7'h51;

  // Protection partitions
  typedef enum logic [3:0] {
    PART_DIAG1 = 4'h0, PART_DIAG2 = 4'h1, PART_SERIAL_ID = 4'h2,
    PART_USER = 4'h3, PART_VENDOR = 4'h4, PART_RESERVED = 4'h5,
    PART_PROGRAM_DATA_RAM = 4'h6, PART_DEVREG1 = 4'h7, PART_DEVREG2 = 4'h8
  } part_t;

  // Source of the read answer
  typedef enum logic [1:0] {
    SRC_ZERO = 2'h0, SRC_MEM = 2'h1, SRC_PW = 2'h2, SRC_PTR = 2'h3
  } src_t;

  // One byte access handed over by the serial engine
  typedef struct packed {
    logic valid;
    logic [6:0] dev_addr;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Stored passwords and per-level permission bits
  typedef struct packed {
    logic [N_LEVELS-1:0][PW_W-1:0] password;
    logic [N_LEVELS-1:0][N_PARTS-1:0] rd_en;
    logic [N_LEVELS-1:0][N_PARTS-1:0] wr_en;
  } access_cfg_t;
endpackage : guard_pkg

// file: host_ctl_model.sv
// Host controller model that offers byte accesses to the guard
`timescale 1ns/1ps
module host_ctl_model
  import guard_pkg::*;
(
  input wire logic clk,
  output host_req_t host_req
);
  initial host_req = '0;
  // One byte offered at a falling edge, taken at the next rising edge
  task automatic xfer(input logic [6:0] dev, input logic wr, input logic [7:0] a,
                      input logic [7:0] dt);
    @(negedge clk);
    host_req <= '{valid: 1'b1, dev_addr: dev, write: wr, addr: a, wdata: dt};
  endtask : xfer
  // Released request: fields inverted so stale values never look valid
  task automatic idle();
    @(negedge clk);
    host_req <= '{valid: 1'b0, dev_addr: ~host_req.dev_addr, write: ~host_req.write,
                  addr: ~host_req.addr, wdata: ~host_req.wdata};
  endtask : idle
endmodule : host_ctl_model

// file: host_table_access_guard.sv
// Host byte access guard: paging, password levels and partition permissions
//
// Operation
// - Only answer as slave; match seven-bit device addresses, never start transfers.
// - Each byte finishes in two clocks, far inside standard and fast bit times.
// - While copy engine writes back memory, withhold acknowledge and drop access.
// - Identification address and diagnostics address both answered, each its own space.
// - Sixteen kbyte memory split in 128-byte tables; pointer selects upper half table.
// - Diagnostics upper: table 1 user, 2 vendor, 3-4 registers, 5-7A program RAM.
// - Table 0 upper user then vendor; lower diag1, diag2, firmware revision.
// - Diagnostics lower half reaches the same bytes whatever the pointer holds.
// - Pointer starts at table 0, whatever the diagnostics device address is.
// - Identification address: serial ID, vendor data, then reserved upper half.
// - Diagnostics bytes 123-126 take the password; byte 127 is the pointer.
// - Password bytes and pointer are open to every level without password.
// - Four stored 32-bit passwords, one per level zero to three.
// - Entered password compared with all four; matching level becomes current.
// - No matching password sets the current level to zero.
// - Nine protection partitions cover all host visible memory.
// - Each level holds one read and one write enable per partition.
// - Map access to partition, check current level bit, access only when set.
// - Invalid table write to pointer ignored; reads of invalid table give zero.
// - Every accepted byte acknowledged with zero; single bytes or sixteen-byte bursts.
`timescale 1ns/1ps
module host_table_access_guard
  import guard_pkg::*;
#(
  parameter int DEPTH = MEM_BYTES
) (
  input wire logic clk,
  input wire logic reset,
  input wire host_req_t host_req,
  input wire logic [6:0] id_dev_addr,
  input wire logic [6:0] diag_dev_addr,
  input wire logic backup_busy,
  input wire access_cfg_t access_cfg,
  output logic host_done,
  output logic host_nack,
  output logic [7:0] host_rdata,
  output logic [1:0] access_level,
  output logic [7:0] table_page_pointer
);
  logic hit_id;
  logic hit_diag;
  logic addressed;
  logic accept;
  part_t part;
  logic mapped;
  logic open_byte;
  logic [MEM_AW-1:0] phys;
  logic permit;
  logic granted;
  logic mem_we;
  logic pw_we;
  logic ptr_we;
  logic ptr_valid;
  logic [1:0] pw_sel;
  logic [PW_W-1:0] password_entry_word;
  logic [PW_W-1:0] next_entry;
  logic [1:0] next_level;
  logic [7:0] mem_rdata;
  logic s1_valid;
  logic s1_nack;
  src_t s1_src;
  logic [1:0] s1_pw_sel;
  src_t next_src;
  logic diag_upper;
  logic id_only;

  assign hit_id = host_req.dev_addr == id_dev_addr;
  assign hit_diag = host_req.dev_addr == diag_dev_addr;
  assign addressed = host_req.valid && (hit_id || hit_diag);
  // copy engine write-back blocks the byte
  assign accept = addressed && !backup_busy;

  // Helpers for the mapping checks
  assign diag_upper = hit_diag && host_req.addr[7];
  assign id_only = hit_id && !hit_diag;

  // route to identification or diagnostics space
  guard_part_map u_map (
    .is_diag(hit_diag),
    .table_sel(table_page_pointer),
    .byte_addr(host_req.addr),
    .part(part),
    .mapped(mapped),
    .open_byte(open_byte),
    .phys(phys)
  );

  // one enable bit per level and partition
  // permission lookup for the current level
  assign permit = host_req.write ? access_cfg.wr_en[access_level][part]
                                 : access_cfg.rd_en[access_level][part];
  assign granted = mapped && permit;

  assign mem_we = accept && host_req.write && granted;

  assign pw_we = accept && host_req.write && open_byte && host_req.addr != PTR_ADDR;
  assign ptr_we = accept && host_req.write && open_byte && host_req.addr == PTR_ADDR;
  assign ptr_valid = host_req.wdata <= TABLE_PROGRAM_DATA_RAM_LAST;
  assign pw_sel = 2'(host_req.addr - PW_FIRST);

  guard_byte_ram #(
    .DEPTH(DEPTH),
    .AW(MEM_AW),
    .WIDTH(8)
  ) u_ram (
    .clk(clk),
    .we(mem_we),
    .addr(phys),
    .wdata(host_req.wdata),
    .rdata(mem_rdata)
  );

  // password word with the written byte merged, first byte most significant
  always_comb begin
    next_entry = password_entry_word;
    next_entry[(3 - pw_sel) * 8 +: 8] = host_req.wdata;
  end

  // highest level with a matching password wins
  always_comb begin
    // no match falls back to level zero
    next_level = LEVEL_RESET;
    for (int i = 0; i < N_LEVELS; i++) begin
      if (access_cfg.password[i] == next_entry) begin
        next_level = 2'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      password_entry_word <= ENTRY_RESET;
    end else if (pw_we) begin
      password_entry_word <= next_entry;
    end
  end

  // level zero until a password is entered
  always_ff @(posedge clk) begin
    if (reset) begin
      access_level <= LEVEL_RESET;
    end else if (pw_we) begin
      access_level <= next_level;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      table_page_pointer <= PTR_RESET;
    end else if (ptr_we && ptr_valid) begin
      table_page_pointer <= host_req.wdata;
    end
  end

  // answer source: refused or invalid reads give zero
  always_comb begin
    next_src = SRC_ZERO;
    if (open_byte) begin
      next_src = (host_req.addr == PTR_ADDR) ? SRC_PTR : SRC_PW;
    end else if (granted) begin
      next_src = SRC_MEM;
    end
  end

  // First stage waits for the memory read
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_valid <= 1'b0;
      s1_nack <= NACK_BIT;
      s1_src <= SRC_ZERO;
      s1_pw_sel <= 2'h0;
    end else begin
      s1_valid <= addressed;
      // accepted bytes are acknowledged with zero
      s1_nack <= accept ? ACK_BIT : NACK_BIT;
      s1_src <= accept ? next_src : SRC_ZERO;
      s1_pw_sel <= pw_sel;
    end
  end

  // answer stage, two clocks after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      host_done <= 1'b0;
      host_nack <= NACK_BIT;
      host_rdata <= 8'h00;
    end else begin
      host_done <= s1_valid;
      host_nack <= s1_nack;
      case (s1_src)
        SRC_MEM: host_rdata <= mem_rdata;
        SRC_PW: host_rdata <= password_entry_word[(3 - s1_pw_sel) * 8 +: 8];
        SRC_PTR: host_rdata <= table_page_pointer;
        default: host_rdata <= 8'h00;
      endcase
    end
  end

  // Checks of the guarded behaviour
  done_latency_a: assert property (
    @(posedge clk) disable iff (reset)
    addressed && !backup_busy |-> ##2 host_done && host_nack == ACK_BIT)
    else $error("accepted byte not acknowledged two clocks later");

  backup_nack_a: assert property (
    @(posedge clk) disable iff (reset)
    addressed && backup_busy |-> !mem_we ##2 host_done && host_nack == NACK_BIT)
    else $error("byte acknowledged during write-back");

  stray_addr_a: assert property (
    @(posedge clk) disable iff (reset)
    host_req.valid && !hit_id && !hit_diag |-> ##2 !host_done)
    else $error("foreign device address answered");

  ptr_invalid_a: assert property (
    @(posedge clk) disable iff (reset)
    ptr_we && host_req.wdata > TABLE_PROGRAM_DATA_RAM_LAST |=> $stable(table_page_pointer))
    else $error("invalid table number stored");

  ptr_store_a: assert property (
    @(posedge clk) disable iff (reset)
    ptr_we && ptr_valid |=> table_page_pointer == $past(host_req.wdata))
    else $error("valid table number not stored");

  reset_state_a: assert property (
    @(posedge clk)
    reset |=> access_level == LEVEL_RESET && table_page_pointer == PTR_RESET)
    else $error("level or pointer not cleared by reset");

  no_match_a: assert property (
    @(posedge clk) disable iff (reset)
    pw_we && access_cfg.password[0] != next_entry && access_cfg.password[1] != next_entry
      && access_cfg.password[2] != next_entry && access_cfg.password[3] != next_entry
      |=> access_level == LEVEL_RESET)
    else $error("unmatched password did not drop to level zero");

  level_match_a: assert property (
    @(posedge clk) disable iff (reset)
    pw_we && access_cfg.password[3] == next_entry |=> access_level == 2'h3)
    else $error("matching password did not raise the level");

  refused_read_a: assert property (
    @(posedge clk) disable iff (reset)
    accept && !host_req.write && !open_byte && !granted |-> ##2 host_rdata == 8'h00)
    else $error("refused read returned data");

  refused_write_a: assert property (
    @(posedge clk) disable iff (reset)
    mem_we |-> mapped && access_cfg.wr_en[access_level][part])
    else $error("write reached memory without permission");

  lower_fixed_a: assert property (
    @(posedge clk) disable iff (reset)
    hit_diag && !host_req.addr[7] |-> phys[MEM_AW-1:7] == SLOT_DIAG_LOWER)
    else $error("diagnostics lower half moved with the pointer");

  open_bytes_a: assert property (
    @(posedge clk) disable iff (reset)
    accept && !host_req.write && hit_diag && host_req.addr == PTR_ADDR
      |-> ##2 host_rdata == $past(table_page_pointer, 2))
    else $error("pointer not readable at this level");

  table_user_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer == TABLE_USER |-> mapped && part == PART_USER)
    else $error("table one not mapped to user memory");

  table_vendor_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer == TABLE_VENDOR |-> mapped && part == PART_VENDOR)
    else $error("table two not mapped to vendor memory");

  devreg_one_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer == TABLE_DEVREG1 |-> mapped && part == PART_DEVREG1)
    else $error("table three not in its register partition");

  devreg_two_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer == TABLE_DEVREG2 |-> mapped && part == PART_DEVREG2)
    else $error("table four not in its register partition");

  program_data_ram_table_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer >= TABLE_PROGRAM_DATA_RAM_FIRST
      && table_page_pointer <= TABLE_PROGRAM_DATA_RAM_LAST |-> mapped && part == PART_PROGRAM_DATA_RAM)
    else $error("program table not mapped to program memory");

  base_user_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer == TABLE_BASE && host_req.addr <= USER0_LAST
      |-> mapped && part == PART_USER)
    else $error("table zero upper byte not in user memory");

  base_vendor_a: assert property (
    @(posedge clk) disable iff (reset)
    diag_upper && table_page_pointer == TABLE_BASE && host_req.addr > USER0_LAST
      |-> mapped && part == PART_VENDOR)
    else $error("table zero top bytes not in vendor memory");

  diag_one_a: assert property (
    @(posedge clk) disable iff (reset)
    hit_diag && host_req.addr <= DIAG1_LAST |-> mapped && part == PART_DIAG1)
    else $error("first diagnostics area mapped wrongly");

  diag_two_a: assert property (
    @(posedge clk) disable iff (reset)
    hit_diag && host_req.addr > DIAG1_LAST && host_req.addr <= DIAG2_LAST
      |-> mapped && part == PART_DIAG2)
    else $error("second diagnostics area mapped wrongly");

  fw_rev_a: assert property (
    @(posedge clk) disable iff (reset)
    hit_diag && host_req.addr > DIAG2_LAST && host_req.addr <= FWREV_LAST
      |-> mapped && part == PART_VENDOR)
    else $error("firmware revision bytes mapped wrongly");

  id_serial_a: assert property (
    @(posedge clk) disable iff (reset)
    id_only && host_req.addr <= ID_LAST |-> mapped && part == PART_SERIAL_ID)
    else $error("serial identification bytes mapped wrongly");

  id_vendor_a: assert property (
    @(posedge clk) disable iff (reset)
    id_only && host_req.addr > ID_LAST && !host_req.addr[7] |-> part == PART_VENDOR)
    else $error("identification vendor bytes mapped wrongly");

  id_reserved_a: assert property (
    @(posedge clk) disable iff (reset)
    id_only && host_req.addr[7] |-> mapped && part == PART_RESERVED)
    else $error("identification upper half not reserved");

  level_one_a: assert property (
    @(posedge clk) disable iff (reset)
    pw_we && access_cfg.password[1] == next_entry && access_cfg.password[2] != next_entry
      && access_cfg.password[3] != next_entry |=> access_level == 2'h1)
    else $error("level one password did not select level one");

  pw_first_a: assert property (
    @(posedge clk) disable iff (reset)
    pw_we && host_req.addr == PW_FIRST
      |=> password_entry_word[31:24] == $past(host_req.wdata))
    else $error("first password byte not stored in the top byte");
endmodule : host_table_access_guard

// file: host_table_access_guard_tb.sv
// Self-checking bench for the host table access guard
`timescale 1ns/1ps
module host_table_access_guard_tb;
  import guard_pkg::*;
  localparam logic [6:0] ID = ID_DEV_DEFAULT;
  localparam logic [6:0] DG = DIAG_DEV_DEFAULT;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic backup_busy = 1'b0;
  access_cfg_t cfg;
  host_req_t host_req;
  logic host_done;
  logic host_nack;
  logic [7:0] host_rdata;
  logic [1:0] access_level;
  logic [7:0] table_page_pointer;
  logic [9:0] expq[$];
  int fail_count = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'hA14BBAD1;
  logic [7:0] d[16];
  logic [7:0] tbl[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h7A};

  host_ctl_model u_host(.clk(clk), .host_req(host_req));
  host_table_access_guard dut(.clk(clk), .reset(reset), .host_req(host_req),
    .id_dev_addr(ID), .diag_dev_addr(DG), .backup_busy(backup_busy), .access_cfg(cfg),
    .host_done(host_done), .host_nack(host_nack), .host_rdata(host_rdata),
    .access_level(access_level), .table_page_pointer(table_page_pointer));

  // Clock generation
  initial begin
    forever #4 clk = ~clk;
  end

  // Random source shared by all scenarios
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction : rnd

  task automatic miss(input logic [8:0] g, input logic [8:0] e);
    fail_count++;
    $display("ERROR t=%0t got %h exp %h", $time, g, e);
  endtask : miss
  // Answer compare: nack always, read data when flagged
  task automatic check_byte(input logic [9:0] e);
    logic [8:0] g;
    g = {host_nack, e[9] ? host_rdata : 8'h00};
    n_checks++;
    if (g !== e[8:0]) miss(g, e[8:0]);
  endtask : check_byte
  task automatic check_reg(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) miss({1'b0, g}, {1'b0, e});
  endtask : check_reg

  // Monitor: each answer takes the oldest note; a stray answer fails
  always @(negedge clk) begin
    if (host_done === 1'b1) check_byte(expq.size() ? expq.pop_front() : 10'h0FF);
  end

  task automatic acc(input logic [6:0] dev, input logic w, input logic [7:0] a,
                     input logic [7:0] dt, input logic [9:0] e);
    expq.push_back(e);
    u_host.xfer(dev, w, a, dt);
  endtask : acc
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] dt);
    acc(dev, 1'b1, a, dt, 10'h000);
  endtask : wr
  task automatic rd(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] e);
    acc(dev, 1'b0, a, 8'(rnd()), {2'b10, e});
  endtask : rd
  task automatic sel(input logic [7:0] t);
    wr(DG, PTR_ADDR, t);
  endtask : sel
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Let the answers land, bounded
  task automatic drain(input string name);
    u_host.idle();
    for (int i = 0; i < 40 && expq.size() > 0; i++) @(negedge clk);
    @(negedge clk);
    if (expq.size() > 0) begin
      miss(9'h0, 9'h0);
      end_of_test();
    end else begin
      $display("Test %s done", name);
    end
  endtask : drain
  task automatic enter(input logic [31:0] w, input logic [1:0] lvl);
    for (int i = 0; i < 4; i++) wr(DG, 8'(PW_FIRST + i), w[31 - 8 * i -: 8]);
    drain("password");
    check_reg({6'h00, access_level}, {6'h00, lvl});
  endtask : enter

  initial begin
    cfg = '0;
    for (int l = 0; l < N_LEVELS; l++) cfg.password[l] = rnd();
    cfg.rd_en[0] = 9'h001;
    cfg.rd_en[3] = 9'h1FF;
    cfg.wr_en[3] = 9'h1FF;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    check_reg({6'h00, access_level}, 8'h00);
    check_reg(table_page_pointer, PTR_RESET);
    rd(DG, PTR_ADDR, 8'h00);
    drain("reset");
    enter(cfg.password[3], 2'd3);
    for (int i = 0; i < 4; i++) rd(DG, 8'(PW_FIRST + i), cfg.password[3][31 - 8 * i -: 8]);
    drain("entry");
    for (int i = 0; i < 7; i++) begin
      d[i] = 8'(rnd());
      sel(tbl[i]);
      wr(DG, 8'h80, d[i]);
    end
    for (int i = 0; i < 7; i++) begin
      sel(tbl[i]);
      rd(DG, 8'h80, d[i]);
    end
    drain("tables");
    sel(8'h7A);
    for (int i = 0; i < 16; i++) d[i] = 8'(rnd());
    for (int i = 0; i < 16; i++) wr(DG, 8'(8'h90 + i), d[i]);
    for (int i = 0; i < 16; i++) rd(DG, 8'(8'h90 + i), d[i]);
    drain("burst");
    // lower half and two device addresses
    sel(8'h05);
    wr(DG, 8'h20, 8'hC3);
    wr(ID, 8'h20, 8'h3C);
    wr(ID, 8'h70, 8'h5A);
    wr(ID, 8'hC0, 8'hA5);
    sel(8'h00);
    rd(DG, 8'h20, 8'hC3);
    rd(ID, 8'h20, 8'h3C);
    rd(ID, 8'h70, 8'h5A);
    rd(ID, 8'hC0, 8'hA5);
    wr(DG, 8'hF8, 8'h96);
    rd(DG, 8'hF8, 8'h96);
    wr(DG, 8'h60, 8'h4B);
    wr(DG, 8'h78, 8'hB4);
    rd(DG, 8'h60, 8'h4B);
    rd(DG, 8'h78, 8'hB4);
    drain("lower");
    sel(8'h7B);
    drain("invalid");
    check_reg(table_page_pointer, 8'h00);
    wr(DG, 8'h80, 8'h11);
    enter(cfg.password[1], 2'd1);
    enter(~cfg.password[3], 2'd0);
    wr(DG, 8'h80, 8'h22);
    rd(DG, 8'h80, 8'h00);
    rd(DG, 8'h20, 8'hC3);
    drain("refused");
    enter(cfg.password[3], 2'd3);
    rd(DG, 8'h80, 8'h11);
    // Let the read pass its edge before the copy engine turns busy
    u_host.idle();
    backup_busy = 1'b1;
    acc(DG, 1'b1, 8'h80, 8'h33, 10'h100);
    acc(DG, 1'b0, 8'h80, 8'h00, 10'h100);
    drain("backup");
    backup_busy = 1'b0;
    rd(DG, 8'h80, 8'h11);
    // foreign device address gets no answer
    u_host.xfer(7'h30, 1'b0, 8'h00, 8'h00);
    rd(DG, PTR_ADDR, 8'h00);
    drain("foreign");
    end_of_test();
  end
endmodule : host_table_access_guard_tb
